// ==== design/register_fis_framer.v ====
`include "register_fis_map.vh"
`default_nettype none
// How it works
// - frame type sits in byte 0
// - register frame type code is 27h
// - five dwords, last dword all zero
// - dword 0: type, flag, command, features
// - dword 1: address bytes and drive select
// - dword 2: expanded address and features
// - dword 3: counts, zero, drive control
// - flag one for command, zero control
// - never send flag with software reset
// - command write or changed control sends
// - identical control writes make no traffic
// - payload is snapshot at transmit start
// - command write sets busy quickly
// - reset bit rise sets busy too
// - shadow access follows drive access locking
// - locked writes dropped, drive reset accepted
// - receive, check type, route fields
// - request link, flow control, report result
// - no receive decode state kept between frames; an owed transmit frame is
module register_fis_framer #(
  parameter [7:0] DEVICE_RESET_CMD = 8'h08  // drive reset opcode, overridable
) (
  input  wire        clock,
  input  wire        rst,
  input  wire        wr_en,             // shadow register write strobe
  input  wire [3:0]  wr_sel,            // which shadow register
  input  wire [7:0]  wr_data,           // value written
  input  wire        data_request_flag, // drive asks for data
  input  wire        busy_clear,        // status update clears busy
  output reg         shadow_busy_flag,  // shadow busy
  output reg  [7:0]  shadow_control,    // drive-control readback
  output reg         tx_frame_req,      // frame wanted from link
  output reg         tx_valid,          // dword on tx_dword valid
  output reg  [31:0] tx_dword,          // outgoing payload dword
  output reg         tx_last,           // final dword of frame
  input  wire        tx_ready,          // link takes dword
  input  wire        tx_ack_ok,         // link: receipt good
  input  wire        tx_ack_err,        // link: receipt bad
  output reg         tx_done_ok,        // pulse: frame delivered
  output reg         tx_done_err,       // pulse: frame failed/dropped
  input  wire        rx_valid,          // incoming dword valid
  input  wire [31:0] rx_dword,          // incoming dword
  input  wire        rx_last,           // final incoming dword
  input  wire        rx_crc_ok,         // crc verdict with rx_last
  output reg         rx_good,           // pulse: frame decoded
  output reg         rx_bad,            // pulse: frame rejected
  output reg         rx_cmd_start,      // pulse: run received command
  output reg         rx_c_flag,         // received update flag
  output reg  [7:0]  rx_command,        // received command byte
  output reg  [15:0] rx_features,       // {exp, low}
  output reg  [47:0] rx_lba,            // {hi_exp..lo_exp, hi..lo}
  output reg  [7:0]  rx_device,         // received drive select
  output reg  [15:0] rx_count,          // {exp, low}
  output reg  [7:0]  rx_control         // received drive control
);

  ////////////////////////////////////////////////////////////////
  // helpers

  // four bytes into one dword, byte 0 lowest
  function [31:0] pack;
    input [7:0] b3;
    input [7:0] b2;
    input [7:0] b1;
    input [7:0] b0;
    begin
      pack = {b3, b2, b1, b0};
    end
  endfunction

  // byte n of a dword
  function [7:0] byte_of;
    input [31:0] d;
    input [1:0]  n;
    begin
      byte_of = d[8*n +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // declarations

  localparam [1:0] ST_IDLE = 2'd0;  // nothing in flight
  localparam [1:0] ST_SEND = 2'd1;  // dwords going out
  localparam [1:0] ST_WAIT = 2'd2;  // waiting for link verdict

  reg  [7:0]  shd_q [0:12];         // shadow registers
  reg  [1:0]  state_q;              // transmit state
  reg  [2:0]  idx_q;                // dword index in flight
  reg  [31:0] snap_q [1:3];         // snapshot of dwords 1 to 3
  reg         pend_q;               // a frame is owed
  reg         pend_c_q;             // owed frame is a command
  reg  [2:0]  ridx_q;               // receive dword index
  reg         rtype_ok_q;           // dword 0 carried our type
  reg         rlong_q;              // more than five dwords
  reg  [31:0] rbuf_q [0:3];         // receive staging
  wire        locked;               // busy or data request
  wire        blk_ok;               // command-block write accepted
  wire        cmd_ok;               // command write accepted
  wire        ctl_wr;               // control write seen
  wire        ctl_chg;              // control write changes value
  wire        software_reset_bit_rise;            // reset bit goes 0 to 1
  wire        start;                // transmission begins
  wire        bad_combo;            // flag plus software reset
  wire [31:0] dw0;                  // dword 0 from the live shadow copy
  wire [31:0] next_dw;              // dword after current
  integer     i;                    // shadow reset loop
  integer     j;                    // snapshot reset loop
  integer     k;                    // receive staging reset loop

  ////////////////////////////////////////////////////////////////
  // write decode

  assign locked = shadow_busy_flag | data_request_flag;
  // locking like a drive
  // a locked write is dropped outright; the drive reset opcode still passes
  assign blk_ok = wr_en && (wr_sel < `SEL_CTRL) &&
                  (!locked || (wr_sel == `SEL_CMD && wr_data == DEVICE_RESET_CMD));
  assign cmd_ok = blk_ok && (wr_sel == `SEL_CMD);
  // control is never locked, so software reset always gets through
  assign ctl_wr = wr_en && (wr_sel == `SEL_CTRL);
  assign ctl_chg = ctl_wr && (wr_data != shd_q[`SEL_CTRL]);
  assign software_reset_bit_rise = ctl_wr && wr_data[`CTL_SOFTWARE_RESET_BIT_BIT] && !shd_q[`SEL_CTRL][`CTL_SOFTWARE_RESET_BIT_BIT];

  // shadow register file; selects above the map are ignored
  always @(posedge clock) begin
    if (rst) begin
      for (i = 0; i <= 12; i = i + 1) begin
        shd_q[i] <= `SHADOW_RST;
      end
    end else if (blk_ok || ctl_wr) begin
      shd_q[wr_sel] <= wr_data;
    end
  end

  // readback of drive control
  always @(posedge clock) begin
    if (rst) begin
      shadow_control <= `SHADOW_RST;
    end else if (ctl_wr) begin
      shadow_control <= wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////
  // busy flag

  // set one edge after the write, far inside BUSY_SET_CYC; set beats clear
  always @(posedge clock) begin
    if (rst) begin
      shadow_busy_flag <= 1'b0;
    end else if (cmd_ok || software_reset_bit_rise) begin
      shadow_busy_flag <= 1'b1;
    end else if (busy_clear) begin
      shadow_busy_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // trigger tracking

  // a write during a frame in flight is owed, not lost; the owed frame
  // carries the flag of the latest command write
  always @(posedge clock) begin
    if (rst) begin
      pend_q   <= 1'b0;
      pend_c_q <= 1'b0;
    end else if (cmd_ok || ctl_chg) begin
      pend_q   <= 1'b1;
      pend_c_q <= cmd_ok | (pend_q & pend_c_q & ~start);
    end else if (start || (state_q == ST_IDLE && pend_q)) begin
      pend_q   <= 1'b0;
      pend_c_q <= 1'b0;
    end
  end

  assign start = (state_q == ST_IDLE) && pend_q && !bad_combo;
  assign bad_combo = pend_c_q && shd_q[`SEL_CTRL][`CTL_SOFTWARE_RESET_BIT_BIT];

  ////////////////////////////////////////////////////////////////
  // snapshot

  // taken at start so later writes cannot tear the frame
  always @(posedge clock) begin
    if (rst) begin
      for (j = 1; j < 4; j = j + 1) begin
        snap_q[j] <= `DWORD_RST;
      end
    end else if (start) begin
      snap_q[1] <= pack(shd_q[`SEL_DEVICE], shd_q[`SEL_LBA_HI],
                        shd_q[`SEL_LBA_MID], shd_q[`SEL_LBA_LO]);
      snap_q[2] <= pack(shd_q[`SEL_FEAT_EXP], shd_q[`SEL_LBA_HI_EXP],
                        shd_q[`SEL_LBA_MID_EXP], shd_q[`SEL_LBA_LO_EXP]);
      snap_q[3] <= pack(shd_q[`SEL_CTRL], 8'h00,
                        shd_q[`SEL_COUNT_EXP], shd_q[`SEL_COUNT]);
    end
  end

  // dword 0 leaves on the start edge itself
  // so it cannot wait for the snapshot and comes from the live copy
  assign dw0 = pack(shd_q[`SEL_FEAT], shd_q[`SEL_CMD], {pend_c_q, 7'h00}, `FIS_TYPE_H2D);

  assign next_dw = (idx_q == 3'd3) ? `DWORD_RST : snap_q[idx_q[1:0] + 2'd1];

  ////////////////////////////////////////////////////////////////
  // transmit state machine

  // dword 0 is built straight from the shadow copy on the start edge
  always @(posedge clock) begin
    if (rst) begin
      state_q      <= ST_IDLE;
      idx_q        <= 3'd0;
      tx_frame_req <= 1'b0;
      tx_valid     <= 1'b0;
      tx_dword     <= `DWORD_RST;
      tx_last      <= 1'b0;
      tx_done_ok   <= 1'b0;
      tx_done_err  <= 1'b0;
    end else begin
      tx_done_ok  <= 1'b0;
      tx_done_err <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q      <= ST_SEND;
            idx_q        <= 3'd0;
            tx_frame_req <= 1'b1;
            tx_valid     <= 1'b1;
            tx_last      <= 1'b0;
            tx_dword     <= dw0;
          end else if (pend_q && bad_combo) begin
            // invalid frame is dropped and reported
            tx_done_err <= 1'b1;
          end
        end
        ST_SEND: begin
          if (tx_ready) begin
            if (idx_q == `FIS_LAST_IDX) begin
              state_q  <= ST_WAIT;
              tx_valid <= 1'b0;
              tx_last  <= 1'b0;
              tx_dword <= `DWORD_RST;
            end else begin
              idx_q    <= idx_q + 3'd1;
              tx_dword <= next_dw;
              tx_last  <= (idx_q == 3'd3);
            end
          end
        end
        ST_WAIT: begin
          // report verdict; ok wins a tie
          if (tx_ack_ok || tx_ack_err) begin
            state_q      <= ST_IDLE;
            tx_frame_req <= 1'b0;
            tx_done_ok   <= tx_ack_ok;
            tx_done_err  <= ~tx_ack_ok;
          end
        end
        default: begin
          state_q      <= ST_IDLE;
          tx_frame_req <= 1'b0;
          tx_valid     <= 1'b0;
          tx_last      <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // receive side

  // per-frame index
  // index restarts after each last dword, so no frame leans on another
  always @(posedge clock) begin
    if (rst) begin
      ridx_q     <= 3'd0;
      rtype_ok_q <= 1'b0;
      rlong_q    <= 1'b0;
      for (k = 0; k < 4; k = k + 1) begin
        rbuf_q[k] <= `DWORD_RST;
      end
    end else if (rx_valid) begin
      if (rx_last) begin
        ridx_q     <= 3'd0;
        rtype_ok_q <= 1'b0;
        rlong_q    <= 1'b0;
      end else begin
        if (ridx_q == `FIS_LAST_IDX) begin
          rlong_q <= 1'b1;
        end else begin
          ridx_q <= ridx_q + 3'd1;
        end
        if (ridx_q < 3'd4) begin
          rbuf_q[ridx_q[1:0]] <= rx_dword;
        end
        if (ridx_q == 3'd0) begin
          rtype_ok_q <= (byte_of(rx_dword, 2'd0) == `FIS_TYPE_H2D);
        end
      end
    end
  end

  // verdict and field routing on the last dword
  always @(posedge clock) begin
    if (rst) begin
      rx_good      <= 1'b0;
      rx_bad       <= 1'b0;
      rx_cmd_start <= 1'b0;
      rx_c_flag    <= 1'b0;
      rx_command   <= 8'h00;
      rx_features  <= 16'h0000;
      rx_lba       <= 48'h0000_0000_0000;
      rx_device    <= 8'h00;
      rx_count     <= 16'h0000;
      rx_control   <= 8'h00;
    end else begin
      rx_good      <= 1'b0;
      rx_bad       <= 1'b0;
      rx_cmd_start <= 1'b0;
      if (rx_valid && rx_last) begin
        if (rx_crc_ok && rtype_ok_q && !rlong_q && ridx_q == `FIS_LAST_IDX) begin
          rx_good     <= 1'b1;
          rx_c_flag   <= rbuf_q[0][`FIS_C_BIT];
          rx_command  <= byte_of(rbuf_q[0], 2'd2);
          rx_features <= {byte_of(rbuf_q[2], 2'd3), byte_of(rbuf_q[0], 2'd3)};
          rx_lba      <= {rbuf_q[2][23:0], rbuf_q[1][23:0]};
          rx_device   <= byte_of(rbuf_q[1], 2'd3);
          rx_count    <= rbuf_q[3][15:0];
          rx_control  <= byte_of(rbuf_q[3], 2'd3);
          rx_cmd_start <= rbuf_q[0][`FIS_C_BIT];
        end else begin
          rx_bad <= 1'b1;
        end
      end
    end
  end

endmodule // register_fis_framer
`default_nettype wire

// ==== design/register_fis_map.vh ====
`ifndef REGISTER_FIS_MAP_VH
`define REGISTER_FIS_MAP_VH
// frame type code and geometry
`define FIS_TYPE_H2D      8'h27
`define FIS_LAST_IDX      3'd4
`define FIS_IDX_W         3
// command-update flag position inside dword 0
`define FIS_C_BIT         15
// software reset bit position inside the drive-control byte
`define CTL_SOFTWARE_RESET_BIT_BIT      2
// shadow register selects on the write port
`define SEL_FEAT          4'h0
`define SEL_FEAT_EXP      4'h1
`define SEL_COUNT         4'h2
`define SEL_COUNT_EXP     4'h3
`define SEL_LBA_LO        4'h4
`define SEL_LBA_MID       4'h5
`define SEL_LBA_HI        4'h6
`define SEL_LBA_LO_EXP    4'h7
`define SEL_LBA_MID_EXP   4'h8
`define SEL_LBA_HI_EXP    4'h9
`define SEL_DEVICE        4'ha
`define SEL_CMD           4'hb
`define SEL_CTRL          4'hc
`define SEL_LAST          4'hc
// reset values
`define SHADOW_RST        8'h00
`define DWORD_RST         32'h0000_0000
// busy flag deadline after a trigger write
`define CLK_PERIOD_NS     4
`define BUSY_SET_NS       400
`define BUSY_SET_CYC      (`BUSY_SET_NS / `CLK_PERIOD_NS)
`endif

// ==== verification/link_partner.sv ====
`default_nettype none
module link_partner (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic nak,        // refuse the next frame
  input  wire logic tx_valid,
  input  wire logic tx_last,
  output logic      tx_ready,
  output logic      tx_ack_ok,
  output logic      tx_ack_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_q;           // cycles left before the verdict
  // random stalls, verdict three cycles after the final dword
  always @(posedge clock) begin
    tx_ack_ok <= 1'b0;
    tx_ack_err <= 1'b0;
    if (rst) begin
      tx_ready <= 1'b0;
      wait_q <= 2'h0;
    end else begin
      tx_ready <= ($urandom % 4) != 0;
      if (tx_valid && tx_ready && tx_last)
        wait_q <= 2'h3;
      else if (wait_q != 2'h0) begin
        wait_q <= wait_q - 2'h1;
        if (wait_q == 2'h1) begin
          tx_ack_ok <= !nak;
          tx_ack_err <= nak;
        end
      end
    end
  end
endmodule // link_partner
`default_nettype wire

// ==== verification/register_fis_monitor.sv ====
`include "register_fis_map.vh"
`default_nettype none
module register_fis_monitor (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        wr_en,
  input wire logic [3:0]  wr_sel,
  input wire logic [7:0]  wr_data,
  input wire logic        data_request_flag,
  input wire logic        shadow_busy_flag,
  input wire logic [7:0]  shadow_control,
  input wire logic        tx_frame_req,
  input wire logic        tx_valid,
  input wire logic [31:0] tx_dword,
  input wire logic        tx_last,
  input wire logic        tx_ready,
  input wire logic        tx_ack_ok,
  input wire logic        tx_done_ok,
  input wire logic        rx_valid,
  input wire logic        rx_last,
  input wire logic        rx_good,
  input wire logic        rx_bad
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic       acc_last;                     // dword 4 taken this cycle
  logic [2:0] acc_q;                        // dwords taken in this frame
  assign acc_last = tx_valid && tx_ready && tx_last;
  // count accepted dwords, wrap at the final one
  always_ff @(posedge clock)
    if (rst || acc_last)
      acc_q <= 3'h0;
    else if (tx_valid && tx_ready)
      acc_q <= acc_q + 3'h1;
  ////////////////////////////////////////////////////////////////
  a_cmd_sets_busy: assert property (wr_en && wr_sel == `SEL_CMD && !shadow_busy_flag && !data_request_flag
    |=> shadow_busy_flag) else $error("busy not set after command write");
  a_software_reset_bit_sets_busy: assert property (wr_en && wr_sel == `SEL_CTRL && wr_data[2] && !shadow_control[2]
    |=> shadow_busy_flag) else $error("busy not set on reset bit rise");
  a_ctrl_keeps_idle: assert property (wr_en && wr_sel == `SEL_CTRL && !shadow_busy_flag && !$past(wr_en)
    && !(wr_data[2] && !shadow_control[2]) |=> !shadow_busy_flag) else $error("busy set by plain control write");
  a_cmd_starts_frame: assert property (wr_en && wr_sel == `SEL_CMD && !shadow_busy_flag && !data_request_flag
    && !tx_frame_req && !shadow_control[2] |-> ##2 tx_frame_req) else $error("command write sent no frame");
  a_type_code_first: assert property ($rose(tx_frame_req) |-> tx_valid && tx_dword[7:0] == `FIS_TYPE_H2D
    && tx_dword[14:8] == 7'h00) else $error("first dword lacks type code");
  a_last_dword_zero: assert property (tx_valid && tx_last |-> tx_dword == 32'h0000_0000)
    else $error("final dword not zero");
  a_five_dwords: assert property (acc_last |-> acc_q == 3'h4) else $error("frame length not five");
  a_offer_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_dword) && $stable(tx_last))
    else $error("offered dword changed before accept");
  a_ack_reports: assert property (tx_frame_req && !tx_valid && tx_ack_ok |=> tx_done_ok && !tx_frame_req)
    else $error("link ack not reported");
  a_rx_verdict: assert property (rx_valid && rx_last |=> rx_good ^ rx_bad) else $error("no single rx verdict");
  a_valid_in_frame: assert property (tx_valid |-> tx_frame_req) else $error("offer outside frame");
  c_frame_done: cover property (tx_done_ok);
  c_rx_bad: cover property (rx_bad);
  c_locked_write: cover property (wr_en && data_request_flag);
endmodule // register_fis_monitor
bind register_fis_framer register_fis_monitor i_register_fis_monitor (.clock(clock), .rst(rst), .wr_en(wr_en),
  .wr_sel(wr_sel), .wr_data(wr_data), .data_request_flag(data_request_flag), .shadow_busy_flag(shadow_busy_flag),
  .shadow_control(shadow_control), .tx_frame_req(tx_frame_req), .tx_valid(tx_valid), .tx_dword(tx_dword),
  .tx_last(tx_last), .tx_ready(tx_ready), .tx_ack_ok(tx_ack_ok), .tx_done_ok(tx_done_ok), .rx_valid(rx_valid),
  .rx_last(rx_last), .rx_good(rx_good), .rx_bad(rx_bad));
`default_nettype wire

// ==== verification/tb.sv ====
`include "register_fis_map.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 0, rst = 1, wr_en = 0, data_request_flag = 0, busy_clear = 0, nak = 0;
  logic        rx_valid = 0, rx_last = 0, rx_crc_ok = 0;
  logic [3:0]  wr_sel = 0;
  logic [7:0]  wr_data = 0;
  logic [31:0] rx_dword = 0;
  logic        tx_ready, tx_ack_ok, tx_ack_err, shadow_busy_flag, tx_frame_req, tx_valid, tx_last;
  logic        tx_done_ok, tx_done_err, rx_good, rx_bad, rx_cmd_start, rx_c_flag;
  logic [7:0]  shadow_control, rx_command, rx_device, rx_control;
  logic [15:0] rx_features, rx_count;
  logic [47:0] rx_lba;
  logic [31:0] tx_dword;
  logic [7:0]  sh [0:12] = '{default: 8'h00};  // shadow model
  logic [32:0] txq [$];                         // expected {last, dword}
  logic [106:0] rxq [$];                        // expected {good, bad, fields}
  logic [104:0] last_rx = '0;                   // fields of last good frame
  int          error_cnt = 0, comparisons = 0, cyc = 0;
  int          ks [7] = '{0, 1, 0, 2, 3, 4, 0}; // rx kinds: good, type, crc, short, long
  register_fis_framer i_register_fis_framer (.clock(clock), .rst(rst), .wr_en(wr_en), .wr_sel(wr_sel),
    .wr_data(wr_data), .data_request_flag(data_request_flag), .busy_clear(busy_clear),
    .shadow_busy_flag(shadow_busy_flag), .shadow_control(shadow_control), .tx_frame_req(tx_frame_req),
    .tx_valid(tx_valid), .tx_dword(tx_dword), .tx_last(tx_last), .tx_ready(tx_ready), .tx_ack_ok(tx_ack_ok),
    .tx_ack_err(tx_ack_err), .tx_done_ok(tx_done_ok), .tx_done_err(tx_done_err), .rx_valid(rx_valid),
    .rx_dword(rx_dword), .rx_last(rx_last), .rx_crc_ok(rx_crc_ok), .rx_good(rx_good), .rx_bad(rx_bad),
    .rx_cmd_start(rx_cmd_start), .rx_c_flag(rx_c_flag), .rx_command(rx_command), .rx_features(rx_features),
    .rx_lba(rx_lba), .rx_device(rx_device), .rx_count(rx_count), .rx_control(rx_control));
  link_partner i_link_partner (.clock(clock), .rst(rst), .nak(nak), .tx_valid(tx_valid), .tx_last(tx_last),
    .tx_ready(tx_ready), .tx_ack_ok(tx_ack_ok), .tx_ack_err(tx_ack_err));
  always #2 clock = ~clock;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons=%0d mismatches=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // one-cycle write; locked writes leave the model untouched
  task automatic wr(input logic [3:0] s, input logic [7:0] d, input logic take = 1'b1);
    @(posedge clock);
    wr_en <= 1'b1;
    wr_sel <= s;
    wr_data <= d;
    if (take)
      sh[s] = d;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  task automatic exp_frame(input logic c);
    txq.push_back({1'b0, sh[0], sh[11], c, 7'h00, `FIS_TYPE_H2D});
    txq.push_back({1'b0, sh[10], sh[6], sh[5], sh[4]});
    txq.push_back({1'b0, sh[1], sh[9], sh[8], sh[7]});
    txq.push_back({1'b0, sh[12], 8'h00, sh[3], sh[2]});
    txq.push_back({1'b1, 32'h0000_0000});
  endtask
  // bounded wait for the verdict pulse, then release busy
  // busy released before the next plain write
  task automatic wait_done(input logic ok, input logic b);
    for (int n = 0; n < 300 && !(tx_done_ok || tx_done_err); n++)
      @(posedge clock);
    chk({tx_done_ok, tx_done_err, shadow_busy_flag, shadow_control}, {ok, !ok, b, sh[12]});
    @(posedge clock);
    busy_clear <= 1'b1;
    @(posedge clock);
    busy_clear <= 1'b0;
  endtask
  // incoming frame; reserved bytes stay random
  task automatic rxf(input int k);
    logic [31:0] d [0:5];
    int          len;
    for (int n = 0; n < 6; n++)
      d[n] = $urandom;
    d[0][7:0] = (k == 1) ? 8'h34 : `FIS_TYPE_H2D;
    len = (k == 3) ? 4 : (k == 4) ? 6 : 5;
    if (k == 0)
      last_rx = {d[0][15], d[0][23:16], d[2][31:24], d[0][31:24], d[2][23:0], d[1][23:0],
                 d[1][31:24], d[3][15:0], d[3][31:24]};
    rxq.push_back({k == 0, k != 0, last_rx});
    for (int n = 0; n < len; n++) begin
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_dword <= d[n];
      rx_last <= (n == len - 1);
      rx_crc_ok <= (k != 2);
    end
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  // watcher: every taken dword and rx verdict against the notes
  always @(posedge clock) begin
    logic [106:0] e;
    if (tx_valid && tx_ready)
      chk({tx_last, tx_dword}, txq.size() ? txq.pop_front() : 34'h2_0000_0000);
    if (rx_good || rx_bad) begin
      e = rxq.size() ? rxq.pop_front() : '1;
      chk({rx_good, rx_bad, rx_c_flag, rx_command, rx_features, rx_lba, rx_device, rx_count, rx_control}, e);
      chk(rx_cmd_start, e[106] & e[104]);
    end
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(32'h540e4d54));
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk({shadow_busy_flag, shadow_control, tx_frame_req}, 10'h000);
    for (int i = 0; i < 11; i++)
      wr(i[3:0], 8'($urandom));
    wr(`SEL_CMD, 8'($urandom));
    exp_frame(1'b1);
    wait_done(1'b1, 1'b1);
    $display("test 1 done: command frame");
    wr(`SEL_CTRL, sh[12]); // equal value, no frame
    nak <= 1'b1;
    wr(`SEL_CTRL, 8'h02);
    exp_frame(1'b0);
    wait_done(1'b0, 1'b0);
    nak <= 1'b0;
    $display("test 2 done: control change and refused frame");
    wr(`SEL_CTRL, 8'h06);
    exp_frame(1'b0);
    wait_done(1'b1, 1'b1);
    wr(`SEL_CTRL, 8'h02);
    exp_frame(1'b0);
    wait_done(1'b1, 1'b0);
    $display("test 3 done: reset bit rise and fall");
    // locked writes dropped, drive reset taken
    data_request_flag <= 1'b1;
    wr(`SEL_FEAT, 8'h5a, 1'b0);
    wr(`SEL_CMD, 8'h20, 1'b0);
    wr(`SEL_CMD, 8'h08);
    exp_frame(1'b1);
    wait_done(1'b1, 1'b1);
    data_request_flag <= 1'b0;
    $display("test 4 done: locked writes");
    wr(`SEL_CMD, 8'($urandom));
    exp_frame(1'b1);
    wr(`SEL_CTRL, 8'h03);
    wr(`SEL_COUNT, 8'h77, 1'b0);
    exp_frame(1'b0);
    wait_done(1'b1, 1'b1);
    wait_done(1'b1, 1'b0);
    $display("test 5 done: owed frame during transfer");
    foreach (ks[i])
      rxf(ks[i]);
    repeat (30) @(posedge clock);
    $display("test 6 done: receive frames");
    chk(txq.size() + rxq.size(), 0);
    print_verdict();
  end
endmodule // tb
`default_nettype wire
